// ==== mie_exec.v ====
// Execute logic for clear-working, clear-watchdog, nibble-swap and direction-load.
// Assumes an APB master; instruction words are written to the instruction register.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "mie_regs.vh"

module mie_exec #(
	parameter FILE_DEPTH = 32
) (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Watchdog side
	input wire watchdog_tick,
	output reg [7:0] watchdog_timer_ff,
	output reg [7:0] prescaler_ff,
	// Port direction latches
	output reg [7:0] dir_a_ff,
	output reg [7:0] dir_b_ff,
	// Execution visibility
	output reg exec_done_ff
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [7:0] wreg_ff;
	reg [7:0] status_ff;
	reg presc_to_watch_ff;
	reg [1:0] phase_ff;
	reg busy_ff;
	reg [11:0] instr_ff;
	reg [7:0] file_mem [0:FILE_DEPTH-1];
	reg [7:0] rd_data;
	integer i;

	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;
	wire file_hit = (paddr[11:7] == 5'h01);
	wire [4:0] fidx = instr_ff[4:0];
	wire [7:0] fval = file_mem[fidx];
	wire [7:0] swapped = {fval[3:0], fval[7:4]};

	function is_dir;
		input [11:0] op;
		begin
			is_dir = ((op & `MIE_DIR_MASK) == `MIE_DIR_VAL) &&
				((op[2:0] == `MIE_DIR_SEL_A) || (op[2:0] == `MIE_DIR_SEL_B));
		end
	endfunction

	function is_swap;
		input [11:0] op;
		begin
			is_swap = ((op & `MIE_SWAP_MASK) == `MIE_SWAP_VAL);
		end
	endfunction

	wire exec_now = busy_ff && (phase_ff == 2'd3);

	// ----------------------------------------
	// APB read mux
	// ----------------------------------------
	always @* begin
		rd_data = 8'h00;
		case (paddr)
			`MIE_OFF_INSTR: rd_data = instr_ff[7:0];
			`MIE_OFF_WREG: rd_data = wreg_ff;
			`MIE_OFF_STATUS: rd_data = status_ff;
			`MIE_OFF_CTRL: rd_data = {6'h00, busy_ff, presc_to_watch_ff};
			`MIE_OFF_DIR6: rd_data = dir_a_ff;
			`MIE_OFF_DIR7: rd_data = dir_b_ff;
			`MIE_OFF_WATCH: rd_data = watchdog_timer_ff;
			`MIE_OFF_PRESC: rd_data = prescaler_ff;
			default: rd_data = file_hit ? file_mem[paddr[6:2]] : 8'h00;
		endcase
	end

	// ----------------------------------------
	// Bus response, zero wait states
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable & ~pwrite) begin
				prdata <= {24'h000000, rd_data};
			end
		end
	end

	// ----------------------------------------
	// Next-value variables
	// ----------------------------------------
	reg [7:0] nxt_wreg;
	reg [7:0] nxt_status;
	reg nxt_presc_to_watch;
	reg [1:0] nxt_phase;
	reg nxt_busy;
	reg [11:0] nxt_instr;
	reg [7:0] nxt_watchdog_timer;
	reg [7:0] nxt_prescaler;
	reg [7:0] nxt_dir_a;
	reg [7:0] nxt_dir_b;
	reg [7:0] nxt_file;
	wire [FILE_DEPTH-1:0] file_we;
	genvar g;

	// ----------------------------------------
	// Decode of the held instruction word
	// ----------------------------------------
	// Writes while busy are dropped to keep the cycle atomic
	wire reg_wr = wr_en && pready && !busy_ff;
	wire op_clear_w = (instr_ff == `MIE_OP_CLEAR_W);
	wire op_clear_watch = (instr_ff == `MIE_OP_CLEAR_WATCH);
	wire op_swap = is_swap(instr_ff);
	wire op_dir = is_dir(instr_ff);
	wire swap_to_file = instr_ff[`MIE_BIT_D];
	wire do_clear_w = exec_now && op_clear_w;
	wire do_clear_watch = exec_now && op_clear_watch;
	wire do_swap_w = exec_now && op_swap && !swap_to_file;
	wire do_swap_f = exec_now && op_swap && swap_to_file;
	wire do_dir = exec_now && op_dir;

	// ----------------------------------------
	// Instruction cycle sequencing
	// ----------------------------------------
	// Bus writes and execution never meet: one needs idle, the other busy
	always @* begin
		nxt_busy = busy_ff;
		nxt_phase = phase_ff;
		nxt_instr = instr_ff;
		if (busy_ff) begin
			nxt_phase = phase_ff + 2'd1;
		end
		if (exec_now) begin
			nxt_busy = 1'b0;
		end
		if (reg_wr && (paddr == `MIE_OFF_INSTR)) begin
			nxt_instr = pwdata[11:0];
			nxt_busy = 1'b1;
			nxt_phase = 2'd0;
		end
	end

	// ----------------------------------------
	// Prescaler assignment
	// ----------------------------------------
	always @* begin
		nxt_presc_to_watch = presc_to_watch_ff;
		if (reg_wr && (paddr == `MIE_OFF_CTRL)) begin
			nxt_presc_to_watch = pwdata[0];
		end
	end

	// ----------------------------------------
	// Watchdog and prescaler counts
	// ----------------------------------------
	// Free running watchdog model; the clear below takes priority
	always @* begin
		nxt_watchdog_timer = watchdog_timer_ff;
		nxt_prescaler = prescaler_ff;
		if (watchdog_tick) begin
			if (presc_to_watch_ff) begin
				nxt_prescaler = prescaler_ff + 8'h01;
				if (prescaler_ff == 8'hff) begin
					nxt_watchdog_timer = watchdog_timer_ff + 8'h01;
				end
			end else begin
				nxt_watchdog_timer = watchdog_timer_ff + 8'h01;
			end
		end
		if (do_clear_watch) begin
			nxt_watchdog_timer = 8'h00;
		end
		if (do_clear_watch && presc_to_watch_ff) begin
			nxt_prescaler = 8'h00;
		end
	end

	// ----------------------------------------
	// Working register
	// ----------------------------------------
	always @* begin
		nxt_wreg = wreg_ff;
		if (reg_wr && (paddr == `MIE_OFF_WREG)) begin
			nxt_wreg = pwdata[7:0];
		end
		if (do_clear_w) begin
			nxt_wreg = 8'h00;
		end
		if (do_swap_w) begin
			nxt_wreg = swapped;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Only the named bits move; the rest keep whatever software wrote
	always @* begin
		nxt_status = status_ff;
		if (reg_wr && (paddr == `MIE_OFF_STATUS)) begin
			nxt_status = pwdata[7:0];
		end
		if (do_clear_w) begin
			nxt_status[`MIE_ST_Z] = 1'b1;
		end
		if (do_clear_watch) begin
			nxt_status[`MIE_ST_TIME_OUT] = 1'b1;
			nxt_status[`MIE_ST_POWER_DOWN] = 1'b1;
		end
	end

	// ----------------------------------------
	// Port direction latches
	// ----------------------------------------
	// Other selectors fall through, so no latch changes for them
	always @* begin
		nxt_dir_a = dir_a_ff;
		nxt_dir_b = dir_b_ff;
		if (do_dir && (instr_ff[2:0] == `MIE_DIR_SEL_A)) begin
			nxt_dir_a = wreg_ff;
		end
		if (do_dir && (instr_ff[2:0] == `MIE_DIR_SEL_B)) begin
			nxt_dir_b = wreg_ff;
		end
	end

	// ----------------------------------------
	// File register writes
	// ----------------------------------------
	// nibble exchange as write data
	always @* begin
		nxt_file = pwdata[7:0];
		if (do_swap_f) begin
			nxt_file = swapped;
		end
	end

	generate
		for (g = 0; g < FILE_DEPTH; g = g + 1) begin : g_file_we
			localparam [4:0] IDX = g;
			assign file_we[g] = (do_swap_f && (fidx == IDX)) ||
				(reg_wr && file_hit && (paddr[6:2] == IDX));
		end
	endgenerate

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wreg_ff <= 8'h00;
			status_ff <= `MIE_STATUS_RST;
			presc_to_watch_ff <= 1'b0;
			phase_ff <= 2'd0;
			busy_ff <= 1'b0;
			instr_ff <= 12'h000;
			watchdog_timer_ff <= 8'h00;
			prescaler_ff <= 8'h00;
			dir_a_ff <= `MIE_DIR_RST;
			dir_b_ff <= `MIE_DIR_RST;
			exec_done_ff <= 1'b0;
			for (i = 0; i < FILE_DEPTH; i = i + 1) begin
				file_mem[i] <= 8'h00;
			end
		end else begin
			wreg_ff <= nxt_wreg;
			status_ff <= nxt_status;
			presc_to_watch_ff <= nxt_presc_to_watch;
			phase_ff <= nxt_phase;
			busy_ff <= nxt_busy;
			instr_ff <= nxt_instr;
			watchdog_timer_ff <= nxt_watchdog_timer;
			prescaler_ff <= nxt_prescaler;
			dir_a_ff <= nxt_dir_a;
			dir_b_ff <= nxt_dir_b;
			exec_done_ff <= exec_now;
			for (i = 0; i < FILE_DEPTH; i = i + 1) begin
				if (file_we[i]) begin
					file_mem[i] <= nxt_file;
				end
			end
		end
	end

endmodule // mie_exec

// ==== mie_regs.vh ====
// Constants for the four-instruction execute block: APB offsets, opcodes, fields.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef MIE_REGS_VH
`define MIE_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MIE_OFF_INSTR 12'h000
`define MIE_OFF_WREG 12'h004
`define MIE_OFF_STATUS 12'h008
`define MIE_OFF_CTRL 12'h00c
`define MIE_OFF_DIR6 12'h010
`define MIE_OFF_DIR7 12'h014
`define MIE_OFF_WATCH 12'h018
`define MIE_OFF_PRESC 12'h01c
`define MIE_OFF_FILE 12'h080

// ----------------------------------------
// Opcodes and fields
// ----------------------------------------
`define MIE_OP_CLEAR_W 12'h040
`define MIE_OP_CLEAR_WATCH 12'h004
`define MIE_SWAP_MASK 12'hfc0
`define MIE_SWAP_VAL 12'h380
`define MIE_DIR_MASK 12'hff8
`define MIE_DIR_VAL 12'h000
`define MIE_DIR_SEL_A 3'h6
`define MIE_DIR_SEL_B 3'h7
`define MIE_BIT_D 5

// ----------------------------------------
// Status bit positions and reset values
// ----------------------------------------
`define MIE_ST_Z 2
`define MIE_ST_POWER_DOWN 3
`define MIE_ST_TIME_OUT 4
`define MIE_STATUS_RST 8'h18
`define MIE_DIR_RST 8'hff
`define MIE_OSC_PER_CYC 4

`endif

// ==== mie_props.sv ====
// Checker for the execute block, bound to its ports.
// Assumes one clock domain and the designer's register offsets.
`timescale 1ns/1ps
module mie_props (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Execute side
	input wire watchdog_tick,
	input wire [7:0] watchdog_timer_ff,
	input wire [7:0] prescaler_ff,
	input wire [7:0] dir_a_ff,
	input wire [7:0] dir_b_ff,
	input wire exec_done_ff
);
// ----
// Opcode copied off the bus, since no port shows it
// ----
reg [11:0] op_ff;
reg asg_ff;
wire wr = psel && penable && pready && pwrite;
wire iw = wr && paddr == 12'h000;
wire clr = exec_done_ff && op_ff == 12'h004;
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		op_ff <= 12'h000;
		asg_ff <= 1'h0;
	end else if (wr) begin
		if (paddr == 12'h000) op_ff <= pwdata[11:0];
		if (paddr == 12'h00c) asg_ff <= pwdata[0];
	end
end
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
AST_WATCH_CLR: assert property (clr |-> watchdog_timer_ff == 8'h00) else $error("watch");
AST_PRE_CLR: assert property (clr && asg_ff |-> prescaler_ff == 8'h00) else $error("pre");
AST_WATCH_STEP: assert property (!$stable(watchdog_timer_ff) |-> exec_done_ff ||
	watchdog_timer_ff == $past(watchdog_timer_ff) + 8'h01) else $error("step");
AST_DIR_A: assert property (!$stable(dir_a_ff) |-> exec_done_ff && op_ff == 12'h006)
	else $error("dira");
AST_DIR_B: assert property (!$stable(dir_b_ff) |-> exec_done_ff && op_ff == 12'h007)
	else $error("dirb");
AST_DONE_ONE: assert property ($rose(exec_done_ff) |=> !exec_done_ff [*4]) else $error("one");
AST_DONE_BND: assert property (iw |=> !exec_done_ff [*3] ##[1:3] exec_done_ff)
	else $error("late");
AST_DONE_SRC: assert property ($rose(exec_done_ff) |-> $past(iw, 5)) else $error("src");
cover property (clr && asg_ff);
cover property (!$stable(dir_a_ff));
cover property (!$stable(dir_b_ff));
endmodule // mie_props
bind mie_exec mie_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.watchdog_tick(watchdog_tick), .watchdog_timer_ff(watchdog_timer_ff),
	.prescaler_ff(prescaler_ff), .dir_a_ff(dir_a_ff), .dir_b_ff(dir_b_ff),
	.exec_done_ff(exec_done_ff)
);

// ==== tb.sv ====
// Bench: APB sequences with expected results.
// Assumes mie_exec with the checker bound in.
`timescale 1ns/1ps
module tb;
reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, watchdog_tick = 1'h0;
reg [11:0] paddr = 12'h0;
reg [31:0] pwdata = 32'h0, rd;
reg [7:0] ea, eb;
wire [31:0] prdata;
wire pready, pslverr, exec_done_ff;
wire [7:0] watchdog_timer_ff, prescaler_ff, dir_a_ff, dir_b_ff;
integer n_fail = 0, total_checks = 0, cyc = 0, s;
mie_exec DUT (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.watchdog_tick(watchdog_tick), .watchdog_timer_ff(watchdog_timer_ff),
	.prescaler_ff(prescaler_ff), .dir_a_ff(dir_a_ff), .dir_b_ff(dir_b_ff),
	.exec_done_ff(exec_done_ff)
);
always #20 pclk = ~pclk;
always @(posedge pclk) begin
	cyc = cyc + 1;
	if (cyc == 3000) begin
		n_fail = n_fail + 1;
		print_verdict;
	end
end
task print_verdict;
	$display("checks %0d mismatches %0d", total_checks, n_fail);
	if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
endtask
task apb(input w, input [11:0] a, input [31:0] d);
	@(posedge pclk);
	psel <= 1'h1;
	penable <= 1'h0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	@(posedge pclk);
	while (pready !== 1'h1) @(posedge pclk);
	rd = prdata;
	psel <= 1'h0;
	penable <= 1'h0;
endtask
task chk(input [7:0] g, input [7:0] e);
	total_checks = total_checks + 1;
	if (g !== e) begin
		n_fail = n_fail + 1;
		$display("MISMATCH %0t got %h exp %h", $time, g, e);
	end
endtask
task rc(input [11:0] a, input [7:0] e);
	apb(1'h0, a, 32'h0);
	chk(rd[7:0], e);
endtask
// Waits for the done pulse, bounded
task x(input [11:0] op);
	integer n;
	apb(1'h1, 12'h0, {20'h0, op});
	for (n = 0; n < 20 && exec_done_ff !== 1'h1; n = n + 1) @(posedge pclk);
	chk(n[7:0], 8'h05);
endtask
// Holds the watchdog tick high for n edges
task tk(input integer n);
	watchdog_tick <= 1'h1;
	repeat (n) @(posedge pclk);
	watchdog_tick <= 1'h0;
endtask
initial begin
	repeat (12) @(posedge pclk);
	presetn <= 1'h1;
	chk(dir_a_ff, 8'hff);
	apb(1'h1, 12'h4, 32'h5a);
	x(12'h040);
	rc(12'h4, 8'h00);
	rc(12'h8, 8'h1c);
	$display("clear working done");
	apb(1'h1, 12'h8c, 32'ha5);
	x(12'h383);
	rc(12'h4, 8'h5a);
	rc(12'h8c, 8'ha5);
	x(12'h3a3);
	rc(12'h8c, 8'h5a);
	rc(12'h8, 8'h1c);
	$display("swap done");
	for (s = 1; s >= 0; s = s - 1) begin
		apb(1'h1, 12'hc, 32'h1);
		tk(9);
		apb(1'h1, 12'hc, s);
		tk(3);
		apb(1'h1, 12'h8, 32'h0);
		chk(watchdog_timer_ff, s ? 8'h00 : 8'h03);
		x(12'h004);
		chk(watchdog_timer_ff, 8'h00);
		chk(prescaler_ff, s ? 8'h00 : 8'h09);
		rc(12'h8, 8'h18);
	end
	$display("watchdog done");
	ea = 8'hff;
	eb = 8'hff;
	for (s = 0; s < 8; s = s + 1) begin
		apb(1'h1, 12'h4, {24'h0, s[3:0], 4'h9});
		x({9'h0, s[2:0]});
		if (s == 6) ea = {s[3:0], 4'h9};
		if (s == 7) eb = {s[3:0], 4'h9};
		chk(dir_a_ff, ea);
		chk(dir_b_ff, eb);
	end
	$display("direction done");
	rc(12'h40, 8'h00);
	print_verdict;
end
endmodule // tb
